// ==== verilog/tc_cfg_consts.vh ====
// Constants for the traffic controller configuration register group.
// Assumes inclusion by bare name from design files under verilog/.
`ifndef TC_CFG_CONSTS_VH
`define TC_CFG_CONSTS_VH

// Register byte offsets
`define OFS_TIMEOUT_LBUS_DMA 8'h00
`define OFS_TIMEOUT_DSP_LCD 8'h04
`define OFS_TIMEOUT_SPARE 8'h08
`define OFS_ENDIAN_CONTROL 8'h0C
`define OFS_SDRAM_POWER 8'h10
`define ADDR_LSB 2
`define ADDR_MSB 7

// Field positions
`define TO_HI_MSB 23
`define TO_HI_LSB 16
`define TO_LO_MSB 7
`define TO_LO_LSB 0
`define ENDIAN_EN_BIT 0
`define ENDIAN_SWAP_BIT 1
`define PWR_IDLE_BIT 0
`define PWR_WARM_BIT 1

// Reset values
`define TIMEOUT_RESET 8'h00
`define ENDIAN_EN_RESET 1'b0
`define ENDIAN_SWAP_RESET 1'b0
`define PWR_WARM_RESET 1'b1
`define PWR_IDLE_RESET 1'b1
`define READ_ZERO 32'h00000000

// Bus codes
`define HTRANS_NONSEQ_BIT 1
`define HRESP_OKAY 1'b0

// Requester indices
`define NUM_REQ 4
`define REQ_DSP 0
`define REQ_DMA 1
`define REQ_LCD 2
`define REQ_LOCAL_BUS 3

`endif

// ==== verilog/starvation_timer.v ====
// One requester's wait counter for dynamic priority promotion.
// Assumes request and grant come from logic on the same clock.
`timescale 1ns/1ns
`include "tc_cfg_consts.vh"

module starvation_timer (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Arbiter side
  input wire enable,
  input wire request,
  input wire grant,
  input wire [7:0] limit,
  // Promotion
  output reg promote_reg
);

  reg [7:0] count_reg;
  reg [7:0] count_next;
  reg promote_next;

  always @* begin
    count_next = count_reg;
    promote_next = 1'b0;
    if (!request || grant || !enable) begin
      count_next = `TIMEOUT_RESET;
    end else begin
      if (count_reg >= limit) begin
        promote_next = 1'b1;
      end else begin
        count_next = count_reg + 8'h01;
      end
    end
    if (enable && request && !grant && limit == `TIMEOUT_RESET) begin
      promote_next = 1'b1;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_reg <= `TIMEOUT_RESET;
      promote_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      promote_reg <= promote_next;
    end
  end

endmodule

// ==== verilog/self_refresh_ctrl.v ====
// Self-refresh sequencing for warm reset and idle requests.
// Assumes the SDRAM side answers entry with a same-clock done level.
`timescale 1ns/1ns
`include "tc_cfg_consts.vh"

module self_refresh_ctrl (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Configuration
  input wire on_warm_reset,
  input wire on_idle,
  // Events
  input wire warm_reset_req,
  input wire idle_req,
  input wire sr_done,
  // Results
  output reg sr_enter_reg,
  output reg idle_ack_reg
);

  localparam [3:0] ST_RUN = 4'h1;
  localparam [3:0] ST_ENTER = 4'h2;
  localparam [3:0] ST_ACK = 4'h4;
  localparam [3:0] ST_HOLD = 4'h8;

  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg sr_enter_next;
  reg idle_ack_next;

  always @* begin
    state_next = state_reg;
    sr_enter_next = 1'b0;
    idle_ack_next = 1'b0;
    case (state_reg)
      ST_RUN: begin
        if (warm_reset_req && on_warm_reset) begin
          state_next = ST_HOLD;
          sr_enter_next = 1'b1;
        end else if (idle_req && on_idle) begin
          state_next = ST_ENTER;
          sr_enter_next = 1'b1;
        end else if (idle_req) begin
          state_next = ST_ACK;
          idle_ack_next = 1'b1;
        end
      end
      ST_ENTER: begin
        sr_enter_next = 1'b1;
        if (sr_done) begin
          state_next = ST_ACK;
          idle_ack_next = 1'b1;
        end
      end
      ST_ACK: begin
        idle_ack_next = idle_req;
        sr_enter_next = sr_enter_reg && idle_req;
        if (!idle_req) begin
          state_next = ST_RUN;
        end
      end
      ST_HOLD: begin
        sr_enter_next = warm_reset_req;
        if (!warm_reset_req) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_RUN;
      sr_enter_reg <= 1'b0;
      idle_ack_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      sr_enter_reg <= sr_enter_next;
      idle_ack_reg <= idle_ack_next;
    end
  end

endmodule

// ==== verilog/tc_priority_endian_sdram_cfg.v ====
// Traffic controller priority, endian and SDRAM power configuration.
// Assumes an AHB-Lite master on hclk; request lines are same-clock logic.
// Operation
// - Waiting requester promoted to high priority after programmed cycles.
// - First time-out: local bus in 23:16, DMA in 7:0, reset zero.
// - Second time-out: DSP in 23:16, LCD in 7:0, reset zero.
// - Third time-out entirely reserved, reads zero, writes ignored.
// - Endian bit 0 enables conversion; bit 1 picks byte or word swap.
// - Warm-reset bit set enters self-refresh on warm reset.
// - Idle bit set enters self-refresh before idle acknowledge.
`timescale 1ns/1ns
`include "tc_cfg_consts.vh"

module tc_priority_endian_sdram_cfg (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // Arbiter requests and grants, DSP DMA LCD local bus
  input wire dynamic_priority,
  input wire [3:0] req,
  input wire [3:0] gnt,
  output reg [3:0] high_priority,
  // Endian block
  output reg endian_enable,
  output reg endian_word_swap,
  // SDRAM power control
  input wire warm_reset_req,
  input wire idle_req,
  input wire sr_done,
  output reg sr_enter,
  output reg idle_ack
);

  reg [7:0] to_local_bus_reg;
  reg [7:0] to_dma_reg;
  reg [7:0] to_dsp_reg;
  reg [7:0] to_lcd_reg;
  reg endian_en_reg;
  reg endian_swap_reg;
  reg pwr_warm_reg;
  reg pwr_idle_reg;
  reg wr_pend_reg;
  reg [7:0] wr_addr_reg;
  reg [31:0] rdata_next;
  wire [3:0] promote;
  wire sr_enter_w;
  wire idle_ack_w;
  wire addr_phase;
  wire [31:0] limits;
  wire [31:0] wr_data;

  // Word offset compare, used for read and write decode
  function hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      hit = (addr[`ADDR_MSB:`ADDR_LSB] == ofs[`ADDR_MSB:`ADDR_LSB]);
    end
  endfunction

  assign addr_phase = hsel && hready && htrans[`HTRANS_NONSEQ_BIT];
  assign wr_data = hwdata;

  // Write phase capture
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else if (hready) begin
      wr_pend_reg <= addr_phase && hwrite;
      wr_addr_reg <= haddr[7:0];
    end
  end

  // Register writes
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      to_local_bus_reg <= `TIMEOUT_RESET;
      to_dma_reg <= `TIMEOUT_RESET;
      to_dsp_reg <= `TIMEOUT_RESET;
      to_lcd_reg <= `TIMEOUT_RESET;
      endian_en_reg <= `ENDIAN_EN_RESET;
      endian_swap_reg <= `ENDIAN_SWAP_RESET;
      pwr_warm_reg <= `PWR_WARM_RESET;
      pwr_idle_reg <= `PWR_IDLE_RESET;
    end else if (wr_pend_reg) begin
      if (hit(wr_addr_reg, `OFS_TIMEOUT_LBUS_DMA)) begin
        to_local_bus_reg <= wr_data[`TO_HI_MSB:`TO_HI_LSB];
        to_dma_reg <= wr_data[`TO_LO_MSB:`TO_LO_LSB];
      end
      if (hit(wr_addr_reg, `OFS_TIMEOUT_DSP_LCD)) begin
        to_dsp_reg <= wr_data[`TO_HI_MSB:`TO_HI_LSB];
        to_lcd_reg <= wr_data[`TO_LO_MSB:`TO_LO_LSB];
      end
      if (hit(wr_addr_reg, `OFS_ENDIAN_CONTROL)) begin
        endian_en_reg <= wr_data[`ENDIAN_EN_BIT];
        endian_swap_reg <= wr_data[`ENDIAN_SWAP_BIT];
      end
      if (hit(wr_addr_reg, `OFS_SDRAM_POWER)) begin
        pwr_warm_reg <= wr_data[`PWR_WARM_BIT];
        pwr_idle_reg <= wr_data[`PWR_IDLE_BIT];
      end
    end
  end

  // Read mux
  always @* begin
    rdata_next = `READ_ZERO;
    if (hit(haddr[7:0], `OFS_TIMEOUT_LBUS_DMA)) begin
      rdata_next[`TO_HI_MSB:`TO_HI_LSB] = to_local_bus_reg;
      rdata_next[`TO_LO_MSB:`TO_LO_LSB] = to_dma_reg;
    end else if (hit(haddr[7:0], `OFS_TIMEOUT_DSP_LCD)) begin
      rdata_next[`TO_HI_MSB:`TO_HI_LSB] = to_dsp_reg;
      rdata_next[`TO_LO_MSB:`TO_LO_LSB] = to_lcd_reg;
    end else if (hit(haddr[7:0], `OFS_TIMEOUT_SPARE)) begin
      rdata_next = `READ_ZERO;
    end else if (hit(haddr[7:0], `OFS_ENDIAN_CONTROL)) begin
      rdata_next[`ENDIAN_EN_BIT] = endian_en_reg;
      rdata_next[`ENDIAN_SWAP_BIT] = endian_swap_reg;
    end else if (hit(haddr[7:0], `OFS_SDRAM_POWER)) begin
      rdata_next[`PWR_WARM_BIT] = pwr_warm_reg;
      rdata_next[`PWR_IDLE_BIT] = pwr_idle_reg;
    end
  end

  // Bus answer, zero wait states
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= `READ_ZERO;
      hreadyout <= 1'b1;
      hresp <= `HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp <= `HRESP_OKAY;
      if (addr_phase && !hwrite) begin
        hrdata <= rdata_next;
      end
    end
  end

  assign limits = {to_local_bus_reg, to_lcd_reg, to_dma_reg, to_dsp_reg};

  genvar i;
  generate
    for (i = 0; i < `NUM_REQ; i = i + 1) begin : g_timer
      starvation_timer u_timer (
        .hclk(hclk),
        .hresetn(hresetn),
        .enable(dynamic_priority),
        .request(req[i]),
        .grant(gnt[i]),
        .limit(limits[8*i+7:8*i]),
        .promote_reg(promote[i])
      );
    end
  endgenerate

  self_refresh_ctrl u_sr (
    .hclk(hclk),
    .hresetn(hresetn),
    .on_warm_reset(pwr_warm_reg),
    .on_idle(pwr_idle_reg),
    .warm_reset_req(warm_reset_req),
    .idle_req(idle_req),
    .sr_done(sr_done),
    .sr_enter_reg(sr_enter_w),
    .idle_ack_reg(idle_ack_w)
  );

  // Output registers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      high_priority <= 4'h0;
      endian_enable <= `ENDIAN_EN_RESET;
      endian_word_swap <= `ENDIAN_SWAP_RESET;
      sr_enter <= 1'b0;
      idle_ack <= 1'b0;
    end else begin
      high_priority <= promote;
      endian_enable <= endian_en_reg;
      endian_word_swap <= endian_swap_reg;
      sr_enter <= sr_enter_w;
      idle_ack <= idle_ack_w;
    end
  end

endmodule

// ==== tb/tc_cfg_props.sv ====
// Checker on the configuration group ports.
// Assumes binding to the top module, one clock.
`timescale 1ns/1ns
module tc_cfg_props (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Bus
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire [31:0] hrdata,
  // Arbiter
  input wire dynamic_priority,
  input wire [3:0] req,
  input wire [3:0] gnt,
  input wire [3:0] high_priority,
  // Endian and SDRAM
  input wire endian_enable,
  input wire idle_req,
  input wire sr_done,
  input wire sr_enter,
  input wire idle_ack
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire rd = hsel && hready && htrans[1] && !hwrite;
  wire wr = hsel && hready && htrans[1] && hwrite;
  chk_prio_cause:
    assert property ($rose(high_priority[2]) |-> $past(req[2]))
      else $error("promotion without request");
  chk_dyn_off:
    assert property (!dynamic_priority [*2] |=> high_priority == 4'h0)
      else $error("promotion while dynamic off");
  chk_grant_clear:
    assert property (gnt[0] [*2] |=> !high_priority[0])
      else $error("promotion kept after grant");
  chk_endian_follow:
    assert property (wr && haddr[7:0] == 8'h0C |->
      ##3 endian_enable == $past(hwdata[0], 2)) else $error("endian stale");
  chk_spare_zero:
    assert property (rd && haddr[7:0] == 8'h08 |=> hrdata == 32'h0)
      else $error("spare not zero");
  chk_resv_zero:
    assert property (rd && haddr[7:3] == 5'h00 |=>
      (hrdata & 32'hFF00FF00) == 32'h0) else $error("reserved set");
  chk_ack_early:
    assert property (sr_enter && !sr_done ##1 !sr_done |=> !$rose(idle_ack))
      else $error("ack before self refresh");
  chk_ack_late:
    assert property ($rose(sr_done) && idle_req |-> ##[1:3] idle_ack)
      else $error("ack missing");
  cover property (high_priority == 4'hF);
  cover property (sr_enter && idle_ack);
  cover property ($rose(endian_enable));
endmodule
bind tc_priority_endian_sdram_cfg tc_cfg_props props (.hclk, .hresetn,
  .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
  .dynamic_priority, .req, .gnt, .high_priority, .endian_enable,
  .idle_req, .sr_done, .sr_enter, .idle_ack);

// ==== tb/sdram_power_model.sv ====
// SDRAM side: reports self-refresh entry after a set lag.
// Assumes entry request is a level on the same clock.
`timescale 1ns/1ns
module sdram_power_model (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Entry handshake
  input wire sr_enter,
  input wire [3:0] lag,
  output reg sr_done
);
  reg [3:0] cnt_reg;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn || !sr_enter) begin
      cnt_reg <= 4'h0;
      sr_done <= 1'b0;
    end else if (cnt_reg == lag) begin
      sr_done <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
endmodule

// ==== tb/tc_priority_endian_sdram_cfg_tb.sv ====
// Self-checking bench for the configuration group.
// Assumes one AHB-Lite slave and the SDRAM model.
`timescale 1ns/1ns
module tc_priority_endian_sdram_cfg_tb;
  reg hclk, hresetn, hsel, hwrite, dynamic_priority, warm_reset_req;
  reg idle_req;
  reg [31:0] haddr, hwdata, q;
  reg [1:0] htrans;
  reg [3:0] req, gnt, lag;
  reg [7:0] hit [0:3];
  wire [31:0] hrdata;
  wire [3:0] high_priority;
  wire hreadyout, hresp, endian_enable, endian_word_swap;
  wire sr_done, sr_enter, idle_ack;
  integer fail_count = 0, checks = 0, i, k;
  tc_priority_endian_sdram_cfg DUT (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .req(req), .gnt(gnt),
    .dynamic_priority(dynamic_priority), .high_priority(high_priority),
    .endian_enable(endian_enable), .endian_word_swap(endian_word_swap),
    .warm_reset_req(warm_reset_req), .idle_req(idle_req),
    .sr_done(sr_done), .sr_enter(sr_enter), .idle_ack(idle_ack));
  sdram_power_model sdram (.hclk(hclk), .hresetn(hresetn),
    .sr_enter(sr_enter), .lag(lag), .sr_done(sr_done));
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task await(input integer s);
    for (k = 0; k < 40; k = k + 1) begin
      @(posedge hclk);
      if (s == 0 && hreadyout === 1'b1 || s == 1 && idle_ack === 1'b1
        || s == 2 && sr_enter === 1'b1) break;
    end
    if (k == 40) begin
      fail_count = fail_count + 1;
      tally_and_finish;
    end
  endtask
  task bus(input w, input [7:0] a, input [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    await(0);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    await(0);
    q = hrdata;
  endtask
  task t_regs;
    bus(0, 8'h00, 0);
    chk(q, 32'h0);
    bus(0, 8'h04, 0);
    chk(q, 32'h0);
    bus(0, 8'h08, 0);
    chk(q, 32'h0);
    chk(hresp, 1'b0);
    bus(0, 8'h14, 0);
    chk(q, 32'h0);
    bus(0, 8'h10, 0);
    chk(q, 32'h3);
    bus(1, 8'h00, 32'h00A5005A);
    bus(0, 8'h00, 0);
    chk(q, 32'h00A5005A);
    bus(1, 8'h04, 32'h00C3003C);
    bus(0, 8'h04, 0);
    chk(q, 32'h00C3003C);
    for (i = 0; i < 4; i = i + 1) begin
      bus(1, 8'h0C, i);
      bus(0, 8'h0C, 0);
      chk(q, i);
      chk({endian_word_swap, endian_enable}, i);
    end
    $display("registers done");
  endtask
  task t_prio;
    bus(1, 8'h00, 32'h00030000);
    bus(1, 8'h04, 32'h00050002);
    dynamic_priority <= 1'b1;
    req <= 4'hF;
    for (i = 1; i <= 10; i = i + 1) begin
      @(posedge hclk);
      #1;
      for (k = 0; k < 4; k = k + 1)
        if (high_priority[k] === 1'b1 && hit[k] == 8'h0) hit[k] = i;
    end
    chk({hit[0], hit[1], hit[2], hit[3]}, 32'h07020405);
    @(posedge hclk);
    gnt <= 4'hF;
    repeat (2) @(posedge hclk);
    #1;
    chk(high_priority, 4'h0);
    @(posedge hclk);
    gnt <= 4'h0;
    dynamic_priority <= 1'b0;
    repeat (8) @(posedge hclk);
    #1;
    chk(high_priority, 4'h0);
    @(posedge hclk);
    req <= 4'h0;
    $display("priority done");
  endtask
  task t_power;
    idle_req <= 1'b1;
    await(1);
    chk({sr_enter, sr_done}, 3);
    idle_req <= 1'b0;
    repeat (4) @(posedge hclk);
    chk({sr_enter, idle_ack}, 0);
    bus(1, 8'h10, 32'h2);
    idle_req <= 1'b1;
    lag <= 4'h0;
    await(1);
    chk(sr_enter, 0);
    idle_req <= 1'b0;
    repeat (4) @(posedge hclk);
    warm_reset_req <= 1'b1;
    await(2);
    chk(sr_enter, 1);
    warm_reset_req <= 1'b0;
    bus(1, 8'h10, 32'h0);
    warm_reset_req <= 1'b1;
    repeat (6) @(posedge hclk);
    chk(sr_enter, 0);
    warm_reset_req <= 1'b0;
    $display("power done");
  endtask
  initial begin
    {hresetn, hsel, hwrite, dynamic_priority} <= 4'h0;
    {warm_reset_req, idle_req, htrans, req, gnt} <= 12'h000;
    {haddr, hwdata} <= 64'h0;
    lag <= 4'h6;
    for (i = 0; i < 4; i = i + 1) hit[i] = 8'h0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_prio;
    t_power;
    tally_and_finish;
  end
  initial begin
    repeat (20000) @(posedge hclk);
    fail_count = fail_count + 1;
    tally_and_finish;
  end
endmodule
